// *** design/lwbt_pkg.sv ***
package lwbt_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] LWBT_WD_CTRL_OFS = 12'h000;
  localparam logic [11:0] LWBT_WD_LOAD_OFS = 12'h004;
  localparam logic [11:0] LWBT_WD_SERV_OFS = 12'h008;
  localparam logic [11:0] LWBT_WD_CNT_OFS = 12'h00c;
  localparam logic [11:0] LWBT_SWI_SET_OFS = 12'h010;
  localparam logic [11:0] LWBT_BT_CTRL_OFS = 12'h014;
  localparam logic [11:0] LWBT_IRQ_STAT_OFS = 12'h018;
  localparam logic [11:0] LWBT_IRQ_MASK_OFS = 12'h01c;

  // ---------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------
  localparam int LWBT_WD_EN_BIT = 0;
  localparam int LWBT_WD_ACT_LSB = 1;
  localparam int LWBT_SWI_NUM = 8;
  localparam int LWBT_BT_EN_BIT = 0;
  localparam int LWBT_BT_SEL_LSB = 1;
  localparam int LWBT_STAT_BT_BIT = 8;
  localparam int LWBT_STAT_WD_BIT = 9;
  localparam int LWBT_STAT_W = 10;
  localparam logic [31:0] LWBT_WD_LOAD_RST = 32'h000f_4240;
  localparam logic [31:0] LWBT_SERV_KEY = 32'h0000_00a5;

  // Watchdog consequence selection
  localparam logic [1:0] LWBT_ACT_SYSRST = 2'h0;
  localparam logic [1:0] LWBT_ACT_LOCRST = 2'h1;
  localparam logic [1:0] LWBT_ACT_FAIL = 2'h2;

  // Bus timeout limit selection
  localparam logic [1:0] LWBT_SEL_8US = 2'h0;
  localparam logic [1:0] LWBT_SEL_64US = 2'h1;
  localparam logic [1:0] LWBT_SEL_256US = 2'h2;
  localparam logic [1:0] LWBT_SEL_INF = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int LWBT_CLK_MHZ = 200;
  localparam int LWBT_T8_US = 8;
  localparam int LWBT_T64_US = 64;
  localparam int LWBT_T256_US = 256;
  localparam int LWBT_T8_CYC = LWBT_T8_US * LWBT_CLK_MHZ;
  localparam int LWBT_T64_CYC = LWBT_T64_US * LWBT_CLK_MHZ;
  localparam int LWBT_T256_CYC = LWBT_T256_US * LWBT_CLK_MHZ;
  localparam int LWBT_US_CYC = LWBT_CLK_MHZ;

  // Local bus access tracking
  typedef struct packed {
    logic start;
    logic done;
    logic vme;
  } lwbt_acc_type;

  // Watchdog consequence outputs
  typedef struct packed {
    logic sys_reset;
    logic local_reset;
    logic board_fail;
  } lwbt_wdo_type;

endpackage

// *** design/lwbt_bus_timer.sv ***
`timescale 1ns/100ps
module lwbt_bus_timer
  import lwbt_pkg::*;
#(
  parameter int CNT_W = 17,
  parameter int T8_CYC = LWBT_T8_CYC,
  parameter int T64_CYC = LWBT_T64_CYC,
  parameter int T256_CYC = LWBT_T256_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic [1:0] sel_i,
  input wire lwbt_acc_type acc_i,
  output logic timeout_o
);

  // ---------------------------------------------------------------
  // Access timer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {LWBT_IDLE, LWBT_RUN, LWBT_HOLD} lwbt_bt_state_type;

  lwbt_bt_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic timeout_r, timeout_nxt;
  logic [CNT_W-1:0] limit;
  logic expired;

  // Limit decode; infinity never expires
  always_comb begin
    limit = '0;
    unique case (sel_i)
      LWBT_SEL_8US: limit = CNT_W'(T8_CYC - 1);
      LWBT_SEL_64US: limit = CNT_W'(T64_CYC - 1);
      LWBT_SEL_256US: limit = CNT_W'(T256_CYC - 1);
      LWBT_SEL_INF: limit = '0;
    endcase
  end

  assign expired = (sel_i != LWBT_SEL_INF) && (cnt_r >= limit);

  // Next state; the error ack ends the access, so the timer holds off
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    timeout_nxt = 1'b0;
    unique case (state_r)
      LWBT_IDLE: begin
        // VME bound cycles are timed elsewhere
        if (acc_i.start && enable_i && !acc_i.vme) begin
          state_nxt = LWBT_RUN;
          cnt_nxt = '0;
        end
      end
      LWBT_RUN: begin
        if (acc_i.done || !enable_i) begin
          state_nxt = LWBT_IDLE;
        end else if (expired) begin
          timeout_nxt = 1'b1;
          state_nxt = LWBT_HOLD;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      LWBT_HOLD: begin
        if (acc_i.done) begin
          state_nxt = LWBT_IDLE;
        end
      end
      default: state_nxt = LWBT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= LWBT_IDLE;
      cnt_r <= '0;
      timeout_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  assign timeout_o = timeout_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_bt_no_vme;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_r == LWBT_IDLE && acc_i.start && acc_i.vme) |=> state_r == LWBT_IDLE;
  endproperty
  a_bt_no_vme: assert property (p_bt_no_vme) else $error("timer started on vme cycle");

  property p_bt_restart;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_r == LWBT_IDLE && acc_i.start && enable_i && !acc_i.vme) |=> cnt_r == '0;
  endproperty
  a_bt_restart: assert property (p_bt_restart) else $error("timer not cleared at access start");

  property p_bt_inf;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (sel_i == LWBT_SEL_INF) |=> !timeout_r;
  endproperty
  a_bt_inf: assert property (p_bt_inf) else $error("timeout with unlimited limit");

endmodule

// *** design/lwbt_top.sv ***
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
// Functional notes
// - Enabled watchdog must be serviced before its interval ends, else it times out.
// - Watchdog timeout asserts the selected system reset, local reset or board fail.
// - Eight software interrupt sources each raise a real hardware interrupt request.
// - Enabled bus timer signals transfer error ack when an access overruns the limit.
// - Bus limit selects 8, 64, 256 microseconds or never.
// - Bus timer stays idle during VME bound cycles.
module lwbt_top
  import lwbt_pkg::*;
#(
  parameter int T8_CYC = LWBT_T8_CYC,
  parameter int T64_CYC = LWBT_T64_CYC,
  parameter int T256_CYC = LWBT_T256_CYC,
  parameter int WD_TICK_CYC = LWBT_US_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic lb_start_i,
  input wire logic lb_done_i,
  input wire logic lb_vme_i,
  output logic transfer_error_ack_o,
  output logic sys_reset_o,
  output logic local_reset_o,
  output logic board_fail_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic wr_acc, rd_acc, hit;
  logic [31:0] rdata;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [2:0] wd_ctrl_r, wd_ctrl_nxt;
  logic [31:0] wd_load_r, wd_load_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic [2:0] bt_ctrl_r, bt_ctrl_nxt;
  logic [LWBT_STAT_W-1:0] stat_r, stat_nxt;
  logic [LWBT_STAT_W-1:0] mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic [15:0] tick_r, tick_nxt;
  lwbt_wdo_type wdo_r, wdo_nxt;
  logic wd_fire;
  logic bt_timeout;
  logic tea_r;
  lwbt_acc_type acc;

  // One cycle of wait state: decode in the first access cycle, pready in the second
  assign wr_acc = psel_i && penable_i && !pready_r && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pready_r && !pwrite_i;

  // Read mux; unmapped addresses answer with pslverr
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr_i)
      LWBT_WD_CTRL_OFS: rdata = {29'h0000_0000, wd_ctrl_r};
      LWBT_WD_LOAD_OFS: rdata = wd_load_r;
      LWBT_WD_SERV_OFS: rdata = 32'h0000_0000;
      LWBT_WD_CNT_OFS: rdata = wd_cnt_r;
      LWBT_SWI_SET_OFS: rdata = 32'h0000_0000;
      LWBT_BT_CTRL_OFS: rdata = {29'h0000_0000, bt_ctrl_r};
      LWBT_IRQ_STAT_OFS: rdata = {22'h00_0000, stat_r};
      LWBT_IRQ_MASK_OFS: rdata = {22'h00_0000, mask_r};
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel_i && penable_i && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !hit;
      prdata_nxt = pwrite_i ? 32'h0000_0000 : rdata;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  // Counts in microsecond ticks so a 32-bit load reaches long intervals
  assign wd_fire = wd_ctrl_r[LWBT_WD_EN_BIT] && (wd_cnt_r == 32'h0000_0000) && (tick_r == 16'h0000);

  always_comb begin
    wd_ctrl_nxt = wd_ctrl_r;
    wd_load_nxt = wd_load_r;
    wd_cnt_nxt = wd_cnt_r;
    tick_nxt = tick_r;
    wdo_nxt = wdo_r;
    if (wr_acc && paddr_i == LWBT_WD_CTRL_OFS) begin
      wd_ctrl_nxt = pwdata_i[2:0];
      wd_cnt_nxt = wd_load_r;
    end
    if (wr_acc && paddr_i == LWBT_WD_LOAD_OFS) begin
      wd_load_nxt = pwdata_i;
    end
    if (!wd_ctrl_r[LWBT_WD_EN_BIT]) begin
      tick_nxt = 16'(WD_TICK_CYC - 1);
    end else if (tick_r != 16'h0000) begin
      tick_nxt = tick_r - 16'h0001;
    end else begin
      tick_nxt = 16'(WD_TICK_CYC - 1);
      if (wd_cnt_r != 32'h0000_0000) begin
        wd_cnt_nxt = wd_cnt_r - 32'h0000_0001;
      end
    end
    // Keyed service write reloads; a stray write cannot restart it
    if (wr_acc && paddr_i == LWBT_WD_SERV_OFS && pwdata_i == LWBT_SERV_KEY) begin
      wd_cnt_nxt = wd_load_r;
      tick_nxt = 16'(WD_TICK_CYC - 1);
    end else if (wd_fire) begin
      // Consequence latches until reset; software cannot unwind a reset
      unique case (wd_ctrl_r[LWBT_WD_ACT_LSB +: 2])
        LWBT_ACT_SYSRST: wdo_nxt.sys_reset = 1'b1;
        LWBT_ACT_LOCRST: wdo_nxt.local_reset = 1'b1;
        default: wdo_nxt.board_fail = 1'b1;
      endcase
      wd_cnt_nxt = wd_load_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_ctrl_r <= 3'h0;
      wd_load_r <= LWBT_WD_LOAD_RST;
      wd_cnt_r <= LWBT_WD_LOAD_RST;
      tick_r <= 16'h0000;
      wdo_r <= '0;
    end else begin
      wd_ctrl_r <= wd_ctrl_nxt;
      wd_load_r <= wd_load_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      tick_r <= tick_nxt;
      wdo_r <= wdo_nxt;
    end
  end

  assign sys_reset_o = wdo_r.sys_reset;
  assign local_reset_o = wdo_r.local_reset;
  assign board_fail_o = wdo_r.board_fail;

  // ---------------------------------------------------------------
  // Local bus timer
  // ---------------------------------------------------------------
  assign acc = '{start: lb_start_i, done: lb_done_i, vme: lb_vme_i};

  always_comb begin
    bt_ctrl_nxt = bt_ctrl_r;
    if (wr_acc && paddr_i == LWBT_BT_CTRL_OFS) begin
      bt_ctrl_nxt = pwdata_i[2:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bt_ctrl_r <= 3'h0;
    end else begin
      bt_ctrl_r <= bt_ctrl_nxt;
    end
  end

  lwbt_bus_timer #(
    .T8_CYC(T8_CYC),
    .T64_CYC(T64_CYC),
    .T256_CYC(T256_CYC)
  ) u_bus_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(bt_ctrl_r[LWBT_BT_EN_BIT]),
    .sel_i(bt_ctrl_r[LWBT_BT_SEL_LSB +: 2]),
    .acc_i(acc),
    .timeout_o(bt_timeout)
  );

  assign tea_r = bt_timeout;
  assign transfer_error_ack_o = tea_r;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  // Read clears, but an event in the same cycle survives the clear
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (rd_acc && paddr_i == LWBT_IRQ_STAT_OFS) begin
      stat_nxt = '0;
    end
    if (wr_acc && paddr_i == LWBT_IRQ_MASK_OFS) begin
      mask_nxt = pwdata_i[LWBT_STAT_W-1:0];
    end
    if (wr_acc && paddr_i == LWBT_SWI_SET_OFS) begin
      stat_nxt[LWBT_SWI_NUM-1:0] = stat_nxt[LWBT_SWI_NUM-1:0] | pwdata_i[LWBT_SWI_NUM-1:0];
    end
    if (bt_timeout) begin
      stat_nxt[LWBT_STAT_BT_BIT] = 1'b1;
    end
    if (wd_fire) begin
      stat_nxt[LWBT_STAT_WD_BIT] = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq_o = irq_r;
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_wd_serv;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_acc && paddr_i == LWBT_WD_SERV_OFS && pwdata_i == LWBT_SERV_KEY) |=> wd_cnt_r == wd_load_r;
  endproperty
  a_wd_serv: assert property (p_wd_serv) else $error("service did not reload watchdog");

  property p_wd_act;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wd_fire && !wr_acc && wd_ctrl_r[LWBT_WD_ACT_LSB +: 2] == LWBT_ACT_LOCRST) |=> local_reset_o;
  endproperty
  a_wd_act: assert property (p_wd_act) else $error("local reset not raised on timeout");

  property p_swi;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_acc && paddr_i == LWBT_SWI_SET_OFS && |(pwdata_i[LWBT_SWI_NUM-1:0] & mask_r[LWBT_SWI_NUM-1:0])
      && !(wr_acc && paddr_i == LWBT_IRQ_MASK_OFS)) |=> irq_o;
  endproperty
  a_swi: assert property (p_swi) else $error("software interrupt not raised");

  property p_tea_once;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    transfer_error_ack_o |=> !transfer_error_ack_o;
  endproperty
  a_tea_once: assert property (p_tea_once) else $error("error ack longer than one cycle");

  // The status set wins over a read clear in the same cycle, so the bit always follows the ack
  property p_tea_stat;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    transfer_error_ack_o |=> stat_r[LWBT_STAT_BT_BIT];
  endproperty
  a_tea_stat: assert property (p_tea_stat) else $error("bus timeout status not set");

endmodule

// *** verification/lwbt_lb_master.sv ***
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Local bus master model
// ---------------------------------------------------------------
module lwbt_lb_master (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic transfer_error_ack_i,
  output logic lb_start_o,
  output logic lb_done_o,
  output logic lb_vme_o
);
  // Idle lines; the qualifier is junk outside a start
  initial begin
    lb_start_o = 1'b0;
    lb_done_o = 1'b0;
    lb_vme_o = 1'b1;
  end

  // One access; len 0 holds it open until the error ack or the 400-edge bound ends it
  task automatic access(input logic vme, input int len, output int lat, output logic got_err);
    int n;
    n = 0;
    lat = -1;
    got_err = 1'b0;
    @(posedge core_clk_i);
    lb_start_o <= 1'b1;
    lb_vme_o <= vme;
    @(posedge core_clk_i);
    lb_start_o <= 1'b0;
    lb_vme_o <= ~vme; // Inverted so a stale value is never trusted
    // Bounded: an unlimited access gives up after 400 edges
    while (n < 400 && !got_err && !(len > 0 && n >= len)) begin
      @(posedge core_clk_i);
      n++;
      if (transfer_error_ack_i === 1'b1) begin
        got_err = 1'b1;
        lat = n;
      end
    end
    lb_done_o <= 1'b1;
    @(posedge core_clk_i);
    lb_done_o <= 1'b0;
  endtask
endmodule

// *** verification/lwbt_top_tb.sv ***
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------
module lwbt_top_tb import lwbt_pkg::*;;
  localparam int T8 = 16;
  localparam int T64 = 32;
  localparam int T256 = 64;
  localparam int TICK = 2;
  int lim [3] = '{T8, T64, T256};
  int n_fail = 0;
  int tests_run = 0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lb_start;
  logic lb_done;
  logic lb_vme;
  logic transfer_error_ack;
  logic sys_rst;
  logic loc_rst;
  logic bfail;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int lat;
  logic got;

  lwbt_top #(.T8_CYC(T8), .T64_CYC(T64), .T256_CYC(T256), .WD_TICK_CYC(TICK)) u_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .lb_start_i(lb_start), .lb_done_i(lb_done),
    .lb_vme_i(lb_vme), .transfer_error_ack_o(transfer_error_ack), .sys_reset_o(sys_rst),
    .local_reset_o(loc_rst), .board_fail_o(bfail), .irq_o(irq));

  lwbt_lb_master u_lbm (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .transfer_error_ack_i(transfer_error_ack),
    .lb_start_o(lb_start), .lb_done_o(lb_done), .lb_vme_o(lb_vme));

  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_regs();
    apb(1'b0, LWBT_WD_LOAD_OFS, 32'h0);
    check(rdat, LWBT_WD_LOAD_RST, "load reset value");
    apb(1'b0, 12'h020, 32'h0);
    check(32'(rerr), 32'h1, "unmapped slverr");
    $display("test_regs done");
  endtask

  // Masked source stays quiet, each unmasked source raises irq
  task automatic test_swi();
    apb(1'b1, LWBT_IRQ_MASK_OFS, 32'h0000_00fe);
    apb(1'b1, LWBT_SWI_SET_OFS, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    check(32'(irq), 32'h0, "masked swi");
    apb(1'b1, LWBT_IRQ_MASK_OFS, 32'h0000_00ff);
    for (int i = 0; i < LWBT_SWI_NUM; i++) begin
      if (i > 0) apb(1'b1, LWBT_SWI_SET_OFS, 32'h1 << i);
      repeat (4) @(posedge core_clk);
      check(32'(irq), 32'h1, "swi irq");
      apb(1'b0, LWBT_IRQ_STAT_OFS, 32'h0);
      check(rdat, 32'h1 << i, "swi status");
      repeat (4) @(posedge core_clk);
      check(32'(irq), 32'h0, "irq after clear");
    end
    $display("test_swi done");
  endtask

  // Each limit, never, VME cycle, restart and disabled timer
  task automatic test_bus();
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, LWBT_BT_CTRL_OFS, 32'((s << 1) | 1));
      u_lbm.access(1'b0, 0, lat, got);
      check(32'(got), 32'h1, "error ack");
      check(32'(lat >= lim[s] - 1 && lat <= lim[s] + 3), 32'h1, "limit");
      apb(1'b0, LWBT_IRQ_STAT_OFS, 32'h0);
      check(rdat, 32'h0000_0100, "bus status");
    end
    apb(1'b1, LWBT_BT_CTRL_OFS, 32'h0000_0007);
    u_lbm.access(1'b0, 0, lat, got);
    check(32'(got), 32'h0, "never limit");
    apb(1'b1, LWBT_BT_CTRL_OFS, 32'h0000_0001);
    u_lbm.access(1'b1, 0, lat, got);
    check(32'(got), 32'h0, "vme cycle");
    // Short access then an overrun: the second is timed afresh
    u_lbm.access(1'b0, T8 - 6, lat, got);
    check(32'(got), 32'h0, "normal end");
    u_lbm.access(1'b0, 0, lat, got);
    check(32'(lat >= T8 - 1 && lat <= T8 + 3), 32'h1, "restart");
    apb(1'b1, LWBT_BT_CTRL_OFS, 32'h0000_0000);
    u_lbm.access(1'b0, 0, lat, got);
    check(32'(got), 32'h0, "disabled");
    $display("test_bus done");
  endtask

  // Serviced watchdog holds off, neglected one fires the chosen action
  task automatic test_wd(input logic [1:0] act, input logic [2:0] exp);
    int n;
    n = 0;
    do_reset();
    apb(1'b1, LWBT_WD_LOAD_OFS, 32'd10);
    apb(1'b1, LWBT_WD_CTRL_OFS, 32'({act, 1'b1}));
    repeat (8) begin
      apb(1'b1, LWBT_WD_SERV_OFS, LWBT_SERV_KEY);
      repeat (6) @(posedge core_clk);
    end
    check(32'({sys_rst, loc_rst, bfail}), 32'h0, "serviced");
    while (!(sys_rst || loc_rst || bfail) && n < 80) begin
      @(posedge core_clk);
      n++;
    end
    check(32'({sys_rst, loc_rst, bfail}), 32'(exp), "action");
    apb(1'b0, LWBT_IRQ_STAT_OFS, 32'h0);
    check(rdat, 32'h0000_0200, "wd status");
    $display("test_wd done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    test_regs();
    test_swi();
    test_bus();
    test_wd(LWBT_ACT_SYSRST, 3'b100);
    test_wd(LWBT_ACT_LOCRST, 3'b010);
    test_wd(LWBT_ACT_FAIL, 3'b001);
    test_wd(2'h3, 3'b001);
    test_done();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
endmodule
